// ---- hdl/cfg_port_pkg.sv ----
// Constants shared by both ends of the parallel configuration readback port
package cfg_port_pkg;
    // Link words
    localparam logic [31:0] PULLUP_WORD = 32'hFFFFFFFF;
    localparam logic [31:0] DUMMY_WORD = 32'hFFFFFFFF;
    localparam logic [31:0] SYNC_WORD = 32'hAA995566;
    localparam logic [31:0] SYNC_SEQ [0:4] = '{32'hFFFFFFFF, 32'h000000BB,
        32'h11220044, 32'hFFFFFFFF, 32'hAA995566};
    localparam logic [2:0] SYNC_SEQ_LEN = 3'h5;
    localparam logic [31:0] NO_OPERATION_WORD = 32'h20000000;
    localparam logic [31:0] CMD_WRITE_HDR = 32'h30008001;
    localparam logic [31:0] FRAME_ADDR_WRITE_HDR = 32'h30002001;
    localparam logic [31:0] FRAME_DATA_READ_HDR = 32'h28006000;
    localparam logic [31:0] READ_HDR_BASE = 32'h28000000;
    localparam logic [31:0] TYPE2_READ_BASE = 32'h48000000;
    // Header fields
    localparam int HDR_TYPE_LSB = 29;
    localparam int HDR_OP_LSB = 27;
    localparam int HDR_REG_LSB = 13;
    localparam int T1_COUNT_W = 11;
    localparam int COUNT_W = 27;
    localparam logic [2:0] TYPE1 = 3'h1;
    localparam logic [2:0] TYPE2 = 3'h2;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    // Configuration register addresses
    localparam logic [4:0] ADDR_FRAME_ADDRESS = 5'h01;
    localparam logic [4:0] ADDR_FRAME_DATA_OUT = 5'h03;
    localparam logic [4:0] ADDR_COMMAND = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h07;
    localparam logic [4:0] ADDR_CONFIG_OPTIONS = 5'h09;
    // Command codes
    localparam logic [4:0] READBACK_CONFIG_COMMAND = 5'h04;
    localparam logic [4:0] START_COMMAND = 5'h05;
    localparam logic [4:0] CRC_RESET_COMMAND = 5'h07;
    localparam logic [4:0] SHUTDOWN_COMMAND = 5'h0B;
    localparam logic [4:0] DESYNCHRONISE_COMMAND = 5'h0D;
    // Status word bits
    localparam int STAT_SYNCED_BIT = 0;
    localparam int STAT_SHUTDOWN_BIT = 1;
    localparam int STAT_READBACK_BIT = 2;
    localparam int STAT_DONE_BIT = 3;
    localparam int STAT_CRC_CLEARED_BIT = 4;
    // Read timing: data valid three cycles after chip select
    localparam int READ_VALID_CYCLES = 3;
    localparam logic [1:0] DEV_READ_LEAD = 2'(READ_VALID_CYCLES - 1);
    localparam logic [1:0] CTRL_CAPTURE_AT = 2'(READ_VALID_CYCLES);
    // Sequence lengths
    localparam int FLUSH_WORDS = 64;
    localparam logic [6:0] REG_READ_STEP = 7'h09;
    localparam logic [6:0] FRAME_READ_STEP = 7'(24 + FLUSH_WORDS);
    localparam logic [6:0] REG_END_STEP = 7'h04;
    localparam logic [6:0] FRAME_END_STEP = 7'h0B;
    // Controller register map (APB byte offsets)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FRAME_START_OFS = 8'h04;
    localparam logic [7:0] READ_LEN_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] LAST_WORD_OFS = 8'h10;
    localparam logic [7:0] CHECKSUM_OFS = 8'h14;
    localparam logic [7:0] WORD_COUNT_OFS = 8'h18;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_FRAME_BIT = 1;
    localparam int CTRL_REG_LSB = 4;
    localparam logic [26:0] READ_LEN_RESET = 27'h0000001;
    // Sequence step kinds
    localparam logic [1:0] K_WRITE = 2'h0;
    localparam logic [1:0] K_READ = 2'h1;
    localparam logic [1:0] K_END = 2'h2;
endpackage : cfg_port_pkg

// ---- hdl/config_port_controller.sv ----
// Controller end: APB-driven sequencer for register and frame readback
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module config_port_controller (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    config_port_if.ctrl link
);
    typedef enum logic [5:0] {
        IDLE = 6'b000001,
        SEND = 6'b000010,
        TURN = 6'b000100,
        SETTLE = 6'b001000,
        READ = 6'b010000,
        WAIT_DONE = 6'b100000
    } ctrl_state_t;

    ctrl_state_t state;
    logic frame_op, post;
    logic [4:0] reg_sel;
    logic [31:0] frame_start, last_word, checksum, word_count;
    logic [26:0] read_len, read_left;
    logic [6:0] idx;
    logic [1:0] cap_cnt;
    logic [33:0] step;
    logic apb_access, apb_write, start, mapped;
    logic [31:0] next_prdata;

    // One step of the outgoing word sequence: {kind, word}
    function automatic logic [33:0] step_of(input logic frame, input logic after,
                                            input logic [6:0] i, input logic [4:0] rsel,
                                            input logic [31:0] far_w, input logic [26:0] len_w);
        logic [1:0] k;
        logic [31:0] w;
        k = cfg_port_pkg::K_WRITE;
        w = cfg_port_pkg::NO_OPERATION_WORD;
        if (!after && i < 7'(cfg_port_pkg::SYNC_SEQ_LEN)) begin
            w = cfg_port_pkg::SYNC_SEQ[i[2:0]];
        end else if (!after && !frame) begin
            unique case (i)
                7'h06: w = cfg_port_pkg::READ_HDR_BASE
                           | (32'(rsel) << cfg_port_pkg::HDR_REG_LSB) | 32'h1;
                cfg_port_pkg::REG_READ_STEP: k = cfg_port_pkg::K_READ;
                default: ;
            endcase
        end else if (!after) begin
            unique case (i)
                7'h06, 7'h09, 7'h11: w = cfg_port_pkg::CMD_WRITE_HDR;
                7'h07: w = 32'(cfg_port_pkg::SHUTDOWN_COMMAND);
                7'h0A: w = 32'(cfg_port_pkg::CRC_RESET_COMMAND);
                7'h12: w = 32'(cfg_port_pkg::READBACK_CONFIG_COMMAND);
                7'h14: w = cfg_port_pkg::FRAME_ADDR_WRITE_HDR;
                7'h15: w = far_w;
                7'h16: w = cfg_port_pkg::FRAME_DATA_READ_HDR;
                7'h17: w = cfg_port_pkg::TYPE2_READ_BASE | 32'(len_w);
                cfg_port_pkg::FRAME_READ_STEP: k = cfg_port_pkg::K_READ;
                default: ;
            endcase
        end else if (!frame) begin
            unique case (i)
                7'h00: w = cfg_port_pkg::CMD_WRITE_HDR;
                7'h01: w = 32'(cfg_port_pkg::DESYNCHRONISE_COMMAND);
                cfg_port_pkg::REG_END_STEP: k = cfg_port_pkg::K_END;
                default: ;
            endcase
        end else begin
            unique case (i)
                7'h01, 7'h04, 7'h07: w = cfg_port_pkg::CMD_WRITE_HDR;
                7'h02: w = 32'(cfg_port_pkg::START_COMMAND);
                7'h05: w = 32'(cfg_port_pkg::CRC_RESET_COMMAND);
                7'h08: w = 32'(cfg_port_pkg::DESYNCHRONISE_COMMAND);
                cfg_port_pkg::FRAME_END_STEP: k = cfg_port_pkg::K_END;
                default: ;
            endcase
        end
        return {k, w};
    endfunction : step_of

    always_comb begin
        step = step_of(frame_op, post, idx, reg_sel, frame_start, read_len);
        apb_access = psel && penable && pready;
        apb_write = apb_access && pwrite;
        start = apb_write && paddr == cfg_port_pkg::CTRL_OFS
                && pwdata[cfg_port_pkg::CTRL_START_BIT] && state == IDLE;
        mapped = 1'b1;
        unique case (paddr)
            cfg_port_pkg::CTRL_OFS: next_prdata = {27'h0, reg_sel} << cfg_port_pkg::CTRL_REG_LSB
                                    | (32'(frame_op) << cfg_port_pkg::CTRL_FRAME_BIT);
            cfg_port_pkg::FRAME_START_OFS: next_prdata = frame_start;
            cfg_port_pkg::READ_LEN_OFS: next_prdata = 32'(read_len);
            cfg_port_pkg::STATUS_OFS: next_prdata = {30'h0, link.config_done, state != IDLE};
            cfg_port_pkg::LAST_WORD_OFS: next_prdata = last_word;
            cfg_port_pkg::CHECKSUM_OFS: next_prdata = checksum;
            cfg_port_pkg::WORD_COUNT_OFS: next_prdata = word_count;
            default: begin
                next_prdata = 32'h0;
                mapped = 1'b0;
            end
        endcase
    end

    // APB slave: one wait state, unmapped offsets answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= next_prdata;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // Order registers; settings are locked while a sequence runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_op <= 1'b0;
            reg_sel <= cfg_port_pkg::ADDR_STATUS;
            frame_start <= 32'h0;
            read_len <= cfg_port_pkg::READ_LEN_RESET;
        end else if (apb_write && state == IDLE) begin
            unique case (paddr)
                cfg_port_pkg::CTRL_OFS: begin
                    frame_op <= pwdata[cfg_port_pkg::CTRL_FRAME_BIT];
                    reg_sel <= pwdata[cfg_port_pkg::CTRL_REG_LSB +: 5];
                end
                cfg_port_pkg::FRAME_START_OFS: frame_start <= pwdata;
                cfg_port_pkg::READ_LEN_OFS: read_len <= pwdata[26:0];
                default: ;
            endcase
        end
    end

    // Link sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= IDLE;
            post <= 1'b0;
            idx <= 7'h0;
            cap_cnt <= 2'h0;
            read_left <= 27'h0;
            last_word <= 32'h0;
            checksum <= 32'h0;
            word_count <= 32'h0;
            link.cs_n <= 1'b1;
            link.direction_select <= 1'b0;
            link.ctrl_data <= cfg_port_pkg::DUMMY_WORD;
            link.ctrl_oe <= 1'b1;
        end else begin
            unique case (state)
                IDLE: begin
                    if (start) begin
                        state <= SEND;
                        post <= 1'b0;
                        idx <= 7'h0;
                        checksum <= 32'h0;
                        word_count <= 32'h0;
                        // Mode arrives with the start write, so frame_op is still stale here
                        read_left <= pwdata[cfg_port_pkg::CTRL_FRAME_BIT] ? read_len : 27'h1;
                    end
                end
                SEND: begin
                    if (step[33:32] == cfg_port_pkg::K_WRITE) begin
                        link.cs_n <= 1'b0;
                        link.ctrl_data <= step[31:0];
                        idx <= idx + 7'h1;
                    end else begin
                        // Chip select goes high a cycle before the direction flips
                        link.cs_n <= 1'b1;
                        state <= step[33:32] == cfg_port_pkg::K_READ ? TURN : WAIT_DONE;
                    end
                end
                TURN: begin
                    link.direction_select <= !link.direction_select;
                    link.ctrl_oe <= link.direction_select;
                    state <= SETTLE;
                end
                SETTLE: begin
                    if (link.direction_select) begin
                        link.cs_n <= 1'b0;
                        cap_cnt <= 2'h0;
                        state <= READ;
                    end else begin
                        state <= SEND;
                    end
                end
                READ: begin
                    if (cap_cnt != cfg_port_pkg::CTRL_CAPTURE_AT) begin
                        cap_cnt <= cap_cnt + 2'h1;
                    end else begin
                        // First capture on the fourth edge after select
                        last_word <= link.data_bus;
                        checksum <= checksum ^ link.data_bus;
                        word_count <= word_count + 32'h1;
                        read_left <= read_left - 27'h1;
                        if (read_left <= 27'h1) begin
                            link.cs_n <= 1'b1;
                            post <= 1'b1;
                            idx <= 7'h0;
                            state <= TURN;
                        end
                    end
                end
                WAIT_DONE: begin
                    // Clock keeps running; finish only once done is back
                    if (link.config_done) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule : config_port_controller

// ---- hdl/config_port_device.sv ----
// Device end: packet processor, command effects and readback driver
`timescale 1ns/1ps
module config_port_device #(
    parameter int WORDS_PER_FRAME = 4,
    parameter int FRAME_COUNT = 8,
    parameter int MEM_AW = $clog2(WORDS_PER_FRAME * FRAME_COUNT)
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    config_port_if.dev link,
    // Frame memory preload
    input wire logic frame_load_en,
    input wire logic [MEM_AW-1:0] frame_load_addr,
    input wire logic [31:0] frame_load_data,
    // State
    output logic synced
);
    localparam int DEPTH = WORDS_PER_FRAME * FRAME_COUNT;

    logic [31:0] frame_mem [DEPTH];
    logic shut_down, readback_en, done, crc_cleared;
    logic [31:0] frame_address, config_options;
    logic [1:0] hdr_op;
    logic [4:0] hdr_reg, rd_reg;
    logic [26:0] words_left, read_left, rd_idx;
    logic [1:0] rd_cnt;
    logic take, payload, hdr1, hdr2, arm_read, cmd_wr, read_mode;
    logic [31:0] in_word, out_word, stat_word, mem_addr;
    logic [26:0] arm_count;

    // Controls are sampled on every rising clock edge
    always_comb begin
        in_word = link.data_bus;
        take = !link.cs_n && !link.direction_select;
        read_mode = !link.cs_n && link.direction_select;
        payload = synced && words_left != 27'h0;
        hdr1 = synced && words_left == 27'h0 && in_word[cfg_port_pkg::HDR_TYPE_LSB +: 3] == cfg_port_pkg::TYPE1;
        hdr2 = synced && words_left == 27'h0 && in_word[cfg_port_pkg::HDR_TYPE_LSB +: 3] == cfg_port_pkg::TYPE2;
        arm_read = take && ((hdr1 && in_word[cfg_port_pkg::HDR_OP_LSB +: 2] == cfg_port_pkg::OP_READ)
                   || (hdr2 && hdr_op == cfg_port_pkg::OP_READ));
        arm_count = hdr1 ? 27'(in_word[cfg_port_pkg::T1_COUNT_W-1:0]) : in_word[26:0];
        cmd_wr = take && payload && hdr_reg == cfg_port_pkg::ADDR_COMMAND;
    end

    // Packet decoder; words before the sync word are not packets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synced <= 1'b0;
            words_left <= 27'h0;
            hdr_op <= 2'h0;
            hdr_reg <= 5'h0;
        end else if (take) begin
            if (!synced) begin
                synced <= in_word == cfg_port_pkg::SYNC_WORD;
            end else if (payload) begin
                words_left <= words_left - 27'h1;
                if (cmd_wr && in_word[4:0] == cfg_port_pkg::DESYNCHRONISE_COMMAND) begin
                    synced <= 1'b0;
                end
            end else if (hdr1) begin
                hdr_op <= in_word[cfg_port_pkg::HDR_OP_LSB +: 2];
                hdr_reg <= in_word[cfg_port_pkg::HDR_REG_LSB +: 5];
                if (in_word[cfg_port_pkg::HDR_OP_LSB +: 2] == cfg_port_pkg::OP_WRITE) begin
                    words_left <= arm_count;
                end
            end else if (hdr2 && hdr_op == cfg_port_pkg::OP_WRITE) begin
                words_left <= arm_count;
            end
        end
    end

    // Command and register write effects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_down <= 1'b0;
            readback_en <= 1'b0;
            done <= 1'b1;
            crc_cleared <= 1'b0;
            frame_address <= 32'h0;
            config_options <= 32'h0;
        end else if (take && payload) begin
            if (cmd_wr) begin
                unique case (in_word[4:0])
                    cfg_port_pkg::SHUTDOWN_COMMAND: begin
                        shut_down <= 1'b1;
                        done <= 1'b0;
                    end
                    cfg_port_pkg::START_COMMAND: begin
                        shut_down <= 1'b0;
                        readback_en <= 1'b0;
                        done <= 1'b1;
                    end
                    cfg_port_pkg::READBACK_CONFIG_COMMAND: readback_en <= 1'b1;
                    cfg_port_pkg::CRC_RESET_COMMAND: crc_cleared <= 1'b1;
                    default: ;
                endcase
            end else if (hdr_reg == cfg_port_pkg::ADDR_FRAME_ADDRESS) begin
                frame_address <= in_word;
            end else if (hdr_reg == cfg_port_pkg::ADDR_CONFIG_OPTIONS) begin
                config_options <= in_word;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (frame_load_en) begin
            frame_mem[frame_load_addr] <= frame_load_data;
        end
    end

    // Readback word selection
    always_comb begin
        stat_word = 32'h0;
        stat_word[cfg_port_pkg::STAT_SYNCED_BIT] = synced;
        stat_word[cfg_port_pkg::STAT_SHUTDOWN_BIT] = shut_down;
        stat_word[cfg_port_pkg::STAT_READBACK_BIT] = readback_en;
        stat_word[cfg_port_pkg::STAT_DONE_BIT] = done;
        stat_word[cfg_port_pkg::STAT_CRC_CLEARED_BIT] = crc_cleared;
        mem_addr = 32'(rd_idx) - 32'(WORDS_PER_FRAME) + frame_address * 32'(WORDS_PER_FRAME);
        unique case (rd_reg)
            cfg_port_pkg::ADDR_STATUS: out_word = stat_word;
            cfg_port_pkg::ADDR_CONFIG_OPTIONS: out_word = config_options;
            cfg_port_pkg::ADDR_FRAME_ADDRESS: out_word = frame_address;
            cfg_port_pkg::ADDR_FRAME_DATA_OUT: begin
                // First frame is the frame buffer's dummy; pipeline tail reads zero
                if (!readback_en || rd_idx < 27'(WORDS_PER_FRAME)) begin
                    out_word = 32'h0;
                end else if (mem_addr < 32'(DEPTH)) begin
                    out_word = frame_mem[mem_addr[MEM_AW-1:0]];
                end else begin
                    out_word = 32'h0;
                end
            end
            default: out_word = 32'h0;
        endcase
    end

    // Readback driver: first word on the pins after the third edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_reg <= 5'h0;
            read_left <= 27'h0;
            rd_idx <= 27'h0;
            rd_cnt <= 2'h0;
            link.dev_data <= 32'h0;
            link.dev_oe <= 1'b0;
        end else if (arm_read) begin
            rd_reg <= hdr1 ? in_word[cfg_port_pkg::HDR_REG_LSB +: 5] : hdr_reg;
            read_left <= arm_count;
            rd_idx <= 27'h0;
        end else if (read_mode) begin
            if (rd_cnt != cfg_port_pkg::DEV_READ_LEAD) begin
                rd_cnt <= rd_cnt + 2'h1;
                link.dev_oe <= 1'b0;
            end else if (read_left != 27'h0) begin
                link.dev_data <= out_word;
                link.dev_oe <= 1'b1;
                read_left <= read_left - 27'h1;
                rd_idx <= rd_idx + 27'h1;
            end else begin
                link.dev_oe <= 1'b0;
            end
        end else begin
            rd_cnt <= 2'h0;
            link.dev_oe <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.config_done <= 1'b1;
        end else begin
            link.config_done <= done;
        end
    end
endmodule : config_port_device

// ---- hdl/config_port_if.sv ----
// Link between the configuration controller and the configuration port
`timescale 1ns/1ps
interface config_port_if;
    logic cs_n;
    logic direction_select;
    logic [31:0] ctrl_data;
    logic ctrl_oe;
    logic [31:0] dev_data;
    logic dev_oe;
    logic [31:0] data_bus;
    logic config_done;

    // Resolved data pins; undriven pins float high through pull-ups
    assign data_bus = ctrl_oe ? ctrl_data : (dev_oe ? dev_data : cfg_port_pkg::PULLUP_WORD);

    modport ctrl(output cs_n, output direction_select, output ctrl_data, output ctrl_oe,
                 input dev_oe, input data_bus, input config_done);
    modport dev(input cs_n, input direction_select, input data_bus,
                output dev_data, output dev_oe, output config_done);
endinterface : config_port_if

// ---- testbench/config_port_sva.sv ----
// Link protocol checks for the configuration port
`timescale 1ns/1ps
module config_port_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic cs_n,
    input wire logic direction_select,
    input wire logic ctrl_oe,
    input wire logic dev_oe,
    input wire logic config_done
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_turn; $fell(cs_n) && direction_select; endsequence
    sequence s_lead; !dev_oe [*3] ##1 dev_oe; endsequence
    AST_CTRL_OWNS: assert property (ctrl_oe == !direction_select)
        else $error("controller enable disagrees with direction");
    AST_DEV_READ_ONLY: assert property (dev_oe |-> direction_select)
        else $error("device drives in write direction");
    AST_DEV_RELEASE: assert property ($rose(cs_n) && direction_select |=> !dev_oe)
        else $error("device kept driving after deselect");
    AST_TURN_DESEL: assert property ($changed(direction_select) |-> cs_n && $past(cs_n))
        else $error("direction changed while selected");
    AST_TURN_ORDER: assert property (s_turn |-> $past(direction_select))
        else $error("select asserted in the turn cycle");
    AST_READ_LEAD: assert property (s_turn |-> s_lead)
        else $error("read data not at third cycle");
    AST_DONE_LOW: assert property ($fell(config_done) |-> !config_done [*8])
        else $error("done rose during shutdown");
    AST_DONE_BACK: assert property ($fell(config_done) |-> ##[1:1000] config_done)
        else $error("done never returned high");
endmodule : config_port_sva

// ---- testbench/parallel_config_readback_port_bench.sv ----
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module parallel_config_readback_port_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fl_en = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, fl_d = 32'h00000000, prdata, rd, ex;
    logic [4:0] fl_a = 5'h00;
    logic pready, pslverr, er, synced;
    int err_count = 0, n_tests = 0, cyc = 0;
    config_port_if config_port_if_i ();
    config_port_controller config_port_controller_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(config_port_if_i));
    config_port_device config_port_device_i (.pclk(pclk), .presetn(presetn),
        .link(config_port_if_i), .frame_load_en(fl_en), .frame_load_addr(fl_a),
        .frame_load_data(fl_d), .synced(synced));
    config_port_sva config_port_sva_i (.pclk(pclk), .presetn(presetn),
        .cs_n(config_port_if_i.cs_n), .direction_select(config_port_if_i.direction_select),
        .ctrl_oe(config_port_if_i.ctrl_oe), .dev_oe(config_port_if_i.dev_oe),
        .config_done(config_port_if_i.config_done));
    always #5 pclk = ~pclk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Answer is taken at the rising edge that sees pready high, then released
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask : rdchk
    task run(input logic [31:0] c);
        apb(1'b1, cfg_port_pkg::CTRL_OFS, c);
        do apb(1'b0, cfg_port_pkg::STATUS_OFS, 32'h00000000); while (rd[0] !== 1'b0);
    endtask : run
    task t_status;
        run(32'h00000071);
        rdchk(cfg_port_pkg::LAST_WORD_OFS, 32'h00000009, "status word");
        rdchk(cfg_port_pkg::WORD_COUNT_OFS, 32'h00000001, "word count");
        $display("status read test finished");
    endtask : t_status
    task t_write_only;
        run(32'h00000041);
        rdchk(cfg_port_pkg::LAST_WORD_OFS, 32'h00000000, "command readback");
        apb(1'b0, 8'h1C, 32'h00000000);
        chk("unmapped error", 32'h00000001, {31'h0, er});
        $display("write-only register test finished");
    endtask : t_write_only
    // Frames from 1 on, four words each: dummy frame, then eighteen words from addresses 4 to 21
    task t_frame;
        ex = 32'h00000000;
        for (int k = 4; k < 22; k++) ex ^= 32'hC0DE0000 + k;
        apb(1'b1, cfg_port_pkg::FRAME_START_OFS, 32'h00000001);
        apb(1'b1, cfg_port_pkg::READ_LEN_OFS, 32'h00000016);
        run(32'h00000003);
        rdchk(cfg_port_pkg::CHECKSUM_OFS, ex, "frame checksum");
        rdchk(cfg_port_pkg::WORD_COUNT_OFS, 32'h00000016, "frame count");
        rdchk(cfg_port_pkg::LAST_WORD_OFS, 32'hC0DE0015, "last frame word");
        rdchk(cfg_port_pkg::STATUS_OFS, 32'h00000002, "done after restart");
        chk("session closed", 32'h00000000, {31'h0, synced});
        run(32'h00000011);
        rdchk(cfg_port_pkg::LAST_WORD_OFS, 32'h00000001, "frame address readback");
        $display("frame readback test finished");
    endtask : t_frame
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            fl_en <= 1'b1; fl_a <= 5'(i); fl_d <= 32'hC0DE0000 + i;
        end
        @(posedge pclk);
        fl_en <= 1'b0;
        t_status();
        t_write_only();
        t_frame();
        test_done();
    end
endmodule : parallel_config_readback_port_bench
